//--- src/lpsr_device.sv
// Summary of operation
// - Entry: CKE low, CS low, CA=100
// - CKE high the cycle before entry
// - NOP right after entry command
// - Stay in self refresh while CKE low
// - Ignore all inputs but CKE inside
// - Refresh at entry, gate internal clock
// - Honour minimum residency before exit
// - Clock may stop, restart before exit
// - Two stable clocks before raising CKE
// - Exit interval from edge after CKE
// - Only NOPs during exit interval
// - CKE high during exit unless re-entry
// - Refresh once before next self refresh
// - All banks idle before entry
// - Bank mask bit blocks bank refresh
// - Segment mask combines with bank mask
// - Mode read encoding, split address edges
// - Data on low byte, first beat
// - Four beats, two-cycle NOP period
// - Mode write spacing after mode read
// - Read to mode read spacing BL/2
// - Write to mode read spacing
// - Bank counter to zero on exit
module lpsr_device #(
   parameter int         RD_LAT     = lpsr_pkg::RD_LAT_DEF,
   parameter int         SR_REF_CYC = lpsr_pkg::SR_REF_CYC_DEF,
   // Arbitrary identification value
   parameter logic [7:0] VENDOR_ID  = 8'h5A
) (
   // System
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Link
   lpsr_link_if.dev        link,
   // Mode register load
   input  wire logic       mr_wr,
   input  wire logic [7:0] mr_addr,
   input  wire logic [7:0] mr_data,
   // Status
   output logic            in_self_refresh,
   output logic            clk_gated,
   output logic            refresh_strobe,
   output logic [7:0]      refresh_bank_en,
   output logic [7:0]      refresh_seg_en,
   output logic [2:0]      bank_count,
   output logic            cmd_error
);

   typedef enum logic [2:0] {D_IDLE, D_SREF, D_EXIT, D_MRR_ADDR, D_MRR_LAT, D_MRR_BURST}
      lpsr_dstate_t;

   if (RD_LAT < 1 || RD_LAT > 15) begin : g_chk_lat
      $error("RD_LAT must be 1 to 15");
   end
   if (SR_REF_CYC < 2 || SR_REF_CYC > 65535) begin : g_chk_ref
      $error("SR_REF_CYC must be 2 to 65535");
   end

   lpsr_dstate_t state_r;
   lpsr_dstate_t state_nxt;
   logic [12:0]  sync1_r;
   logic [12:0]  sync2_r;
   logic         ck_prev_r;
   logic [15:0]  xsr_cnt_r;
   logic [15:0]  xsr_nxt;
   logic [15:0]  ref_tmr_r;
   logic [3:0]   lat_cnt_r;
   logic [3:0]   lat_nxt;
   logic [1:0]   beat_r;
   logic [1:0]   beat_nxt;
   logic [1:0]   mode_read_period_cnt_r;
   logic [1:0]   mode_read_period_nxt;
   logic [7:0]   addr_r;
   logic [7:0]   addr_nxt;
   logic         err_nxt;
   logic         cmd_error_r;
   logic [7:0]   bank_mask_r;
   logic [7:0]   seg_mask_r;
   logic [2:0]   bank_cnt_r;
   logic         in_sref_r;
   logic         strobe_r;
   logic [7:0]   bank_en_r;
   logic [7:0]   seg_en_r;
   logic [15:0]  dq_out_r;
   logic         dq_oe_r;
   logic [1:0]   dqs_out_r;

   // Synchronised pins
   wire       ck_s   = sync2_r[12];
   wire       cke_s  = sync2_r[11];
   wire       cs_n_s = sync2_r[10];
   wire [9:0] ca_s   = sync2_r[9:0];
   wire       ck_rise = ck_s & ~ck_prev_r;
   wire       ck_fall = ~ck_s & ck_prev_r;

   // Command decode at the rising link edge
   wire cmd_valid = ck_rise & ~cs_n_s;
   wire is_sre    = cmd_valid & ~cke_s & (ca_s[2:0] == lpsr_pkg::CA_SREF);
   wire is_mrr    = cmd_valid & cke_s & (ca_s[3:0] == lpsr_pkg::CA_MRR);
   wire is_all_bank_refresh  = cmd_valid & cke_s & (ca_s[3:0] == lpsr_pkg::CA_ALL_BANK_REFRESH);
   wire is_single_bank_refresh  = cmd_valid & cke_s & (ca_s[3:0] == lpsr_pkg::CA_SINGLE_BANK_REFRESH);
   wire idle      = (state_r == D_IDLE);
   wire exit_edge = (state_r == D_SREF) & ck_rise & cke_s;

   // Internal refresh timer, runs without the link clock
   wire sr_enter = (state_nxt == D_SREF) & (state_r != D_SREF);
   wire ref_due  = sr_enter | ((state_r == D_SREF) & (ref_tmr_r == 16'h0000));
   wire [15:0] ref_tmr_nxt = ref_due ? 16'(SR_REF_CYC - 1) :
                             (state_r == D_SREF) ? ref_tmr_r - 16'h0001 : ref_tmr_r;

   // bank counter realigned on exit and all-bank refresh
   wire [2:0] bank_cnt_nxt = (exit_edge | (idle & is_all_bank_refresh)) ? 3'h0 :
                             (idle & is_single_bank_refresh) ? bank_cnt_r + 3'h1 : bank_cnt_r;

   // bank mask, segment mask, both write-only
   wire wr_bank = mr_wr & (mr_addr == lpsr_pkg::MR_BANK_MASK);
   wire wr_seg  = mr_wr & (mr_addr == lpsr_pkg::MR_SEG_MASK);

   // only the low byte of the first beat is meaningful
   wire [7:0]  mr_rd     = (addr_r == lpsr_pkg::MR_VENDOR) ? VENDOR_ID : 8'h00;
   wire        burst_nxt = (state_nxt == D_MRR_BURST);
   wire [15:0] dq_nxt    = (burst_nxt & (beat_nxt == 2'h0)) ? {8'h00, mr_rd} : 16'h0000;
   wire [1:0]  dqs_nxt   = {2{burst_nxt & ~beat_nxt[0]}};

   always_comb
   begin
      state_nxt = state_r;
      xsr_nxt   = xsr_cnt_r;
      lat_nxt   = lat_cnt_r;
      beat_nxt  = beat_r;
      addr_nxt  = addr_r;
      mode_read_period_nxt  = mode_read_period_cnt_r;
      err_nxt   = cmd_error_r;
      if (ck_rise && mode_read_period_cnt_r != 2'h0)
         mode_read_period_nxt = mode_read_period_cnt_r - 2'h1;
      // only NOPs inside the mode read period
      if (cmd_valid && mode_read_period_cnt_r != 2'h0)
         err_nxt = 1'b1;
      case (state_r)
         D_IDLE:
         begin
            if (is_sre)
               state_nxt = D_SREF;
            else if (is_mrr)
            begin
               addr_nxt  = {ca_s[9:4], 2'h0};
               lat_nxt   = 4'(RD_LAT);
               mode_read_period_nxt  = 2'(lpsr_pkg::MODE_READ_PERIOD_CK - 1);
               state_nxt = D_MRR_ADDR;
            end
         end
         D_SREF:
         begin
            // only a CKE high edge leaves
            if (exit_edge)
            begin
               xsr_nxt   = 16'(lpsr_pkg::XSR_CYC);
               state_nxt = D_EXIT;
            end
         end
         D_EXIT:
         begin
            // re-entry allowed during the exit interval
            if (is_sre)
               state_nxt = D_SREF;
            else
            begin
               // any command or CKE low inside the interval is flagged
               if (cmd_valid || (ck_rise && !cke_s))
                  err_nxt = 1'b1;
               // interval counted from the exit edge
               if (xsr_cnt_r == 16'h0000)
                  state_nxt = D_IDLE;
               else
                  xsr_nxt = xsr_cnt_r - 16'h0001;
            end
         end
         D_MRR_ADDR:
         begin
            // low address bits from the falling edge
            if (ck_fall)
            begin
               addr_nxt[1:0] = ca_s[1:0];
               state_nxt     = D_MRR_LAT;
            end
         end
         D_MRR_LAT:
         begin
            if (ck_rise)
            begin
               if (lat_cnt_r == 4'h1)
               begin
                  beat_nxt  = 2'h0;
                  state_nxt = D_MRR_BURST;
               end
               else
                  lat_nxt = lat_cnt_r - 4'h1;
            end
         end
         D_MRR_BURST:
         begin
            // four beats, one per link edge, never cut short
            if (ck_rise || ck_fall)
            begin
               if (beat_r == 2'h3)
                  state_nxt = D_IDLE;
               else
                  beat_nxt = beat_r + 2'h1;
            end
         end
         default: state_nxt = D_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r   <= 13'h0000;
         sync2_r   <= 13'h0000;
         ck_prev_r <= 1'b0;
      end
      else
      begin
         sync1_r   <= {link.ck, link.cke, link.cs_n, link.ca};
         sync2_r   <= sync1_r;
         ck_prev_r <= ck_s;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r     <= D_IDLE;
         xsr_cnt_r   <= 16'h0000;
         lat_cnt_r   <= 4'h0;
         beat_r      <= 2'h0;
         addr_r      <= 8'h00;
         mode_read_period_cnt_r  <= 2'h0;
         cmd_error_r <= 1'b0;
         ref_tmr_r   <= 16'h0000;
         bank_cnt_r  <= 3'h0;
      end
      else
      begin
         state_r     <= state_nxt;
         xsr_cnt_r   <= xsr_nxt;
         lat_cnt_r   <= lat_nxt;
         beat_r      <= beat_nxt;
         addr_r      <= addr_nxt;
         mode_read_period_cnt_r  <= mode_read_period_nxt;
         cmd_error_r <= err_nxt;
         ref_tmr_r   <= ref_tmr_nxt;
         bank_cnt_r  <= bank_cnt_nxt;
      end
   end

   // Masks reset to refresh-everything
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_mask_r <= lpsr_pkg::MASK_RST;
         seg_mask_r  <= lpsr_pkg::MASK_RST;
      end
      else
      begin
         if (wr_bank)
            bank_mask_r <= mr_data;
         if (wr_seg)
            seg_mask_r <= mr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_sref_r <= 1'b0;
         strobe_r  <= 1'b0;
         bank_en_r <= 8'h00;
         seg_en_r  <= 8'h00;
         dq_out_r  <= 16'h0000;
         dq_oe_r   <= 1'b0;
         dqs_out_r <= 2'h0;
      end
      else
      begin
         in_sref_r <= (state_nxt == D_SREF);
         strobe_r  <= ref_due;
         // a cell refreshes only if neither mask blocks it
         bank_en_r <= ~bank_mask_r;
         seg_en_r  <= ~seg_mask_r;
         dq_out_r  <= dq_nxt;
         dq_oe_r   <= burst_nxt;
         dqs_out_r <= dqs_nxt;
      end
   end

   assign link.dq_out     = dq_out_r;
   assign link.dq_oe      = dq_oe_r;
   assign link.dqs_out    = dqs_out_r;
   assign link.dqs_oe     = dq_oe_r;
   assign in_self_refresh = in_sref_r;
   // internal clock gated while in self refresh
   assign clk_gated       = in_sref_r;
   assign refresh_strobe  = strobe_r;
   assign refresh_bank_en = bank_en_r;
   assign refresh_seg_en  = seg_en_r;
   assign bank_count      = bank_cnt_r;
   assign cmd_error       = cmd_error_r;

endmodule : lpsr_device

//--- inc/lpsr_pkg.sv
package lpsr_pkg;
   // System clock rate and link clock divider
   localparam int         CLK_MHZ        = 40;
   localparam logic [2:0] CK_RISE_SLOT   = 3'h5;
   localparam logic [2:0] CK_FALL_SLOT   = 3'h1;
   // Timing in nanoseconds and derived pclk counts (least times round up)
   localparam int         CKESR_NS       = 15;
   localparam int         XSR_NS         = 140;
   localparam int         REF_INT_NS     = 7800;
   localparam int         CKESR_CYC      = (CKESR_NS * CLK_MHZ + 999) / 1000;
   localparam int         XSR_CYC        = (XSR_NS * CLK_MHZ + 999) / 1000;
   localparam int         SR_REF_CYC_DEF = (REF_INT_NS * CLK_MHZ) / 1000;
   // Slack for the two-flop delay on the far end
   localparam int         SYNC_MARGIN    = 8;
   localparam int         RD_LAT_DEF     = 3;
   localparam int         MODE_READ_PERIOD_CK        = 2;
   localparam int         MRR_GAP_CK     = 2;
   // Command/address encodings, ca[3:0], self refresh entry on ca[2:0]
   localparam logic [2:0] CA_SREF        = 3'h4;
   localparam logic [3:0] CA_MRR         = 4'h8;
   localparam logic [3:0] CA_ALL_BANK_REFRESH       = 4'hC;
   localparam logic [3:0] CA_SINGLE_BANK_REFRESH       = 4'h4;
   // Mode register numbers
   localparam logic [7:0] MR_BANK_MASK   = 8'h10;
   localparam logic [7:0] MR_SEG_MASK    = 8'h11;
   localparam logic [7:0] MR_VENDOR      = 8'h05;
   localparam logic [7:0] MASK_RST       = 8'h00;
   // Controller register offsets and fields
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_MRR_CMD    = 8'h04;
   localparam logic [7:0] OFS_MRR_DATA   = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam int         ST_SREF_BIT    = 0;
   localparam int         ST_BUSY_BIT    = 1;
   localparam int         ST_DONE_BIT    = 2;
endpackage : lpsr_pkg

//--- inc/lpsr_link_if.sv
interface lpsr_link_if;
   logic        ck;
   logic        cke;
   logic        cs_n;
   logic [9:0]  ca;
   logic [15:0] dq_out;
   logic        dq_oe;
   logic [1:0]  dqs_out;
   logic        dqs_oe;
   logic [15:0] dq;
   logic [1:0]  dqs;

   // Undriven data lines read as low
   assign dq  = dq_oe ? dq_out : 16'h0000;
   assign dqs = dqs_oe ? dqs_out : 2'h0;

   modport ctrl (output ck, output cke, output cs_n, output ca, input dq, input dqs);
   modport dev  (input ck, input cke, input cs_n, input ca,
                 output dq_out, output dq_oe, output dqs_out, output dqs_oe);
endinterface : lpsr_link_if

//--- src/lpsr_ctrl.sv
module lpsr_ctrl (
   // System
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   lpsr_link_if.ctrl        link
);

   typedef enum logic [2:0] {C_IDLE, C_SRE, C_SREF, C_EXIT, C_REF, C_MRR, C_MRR_WAIT}
      lpsr_cstate_t;

   lpsr_cstate_t state_r;
   lpsr_cstate_t state_nxt;
   logic [2:0]   div_r;
   logic         ck_r;
   logic         cke_r;
   logic         cke_nxt;
   logic         cs_n_r;
   logic         cs_n_nxt;
   logic [9:0]   ca_r;
   logic [9:0]   ca_nxt;
   logic [15:0]  cnt_r;
   logic [15:0]  cnt_nxt;
   logic [1:0]   gap_r;
   logic [1:0]   gap_nxt;
   logic [8:0]   sync1_r;
   logic [8:0]   sync2_r;
   logic         dqs_prev_r;
   logic         got_r;
   logic         sref_req_r;
   logic         mrr_go_r;
   logic [7:0]   mrr_addr_r;
   logic [7:0]   mrr_data_r;
   logic         done_r;
   logic         pready_r;
   logic         pslverr_r;
   logic [31:0]  prdata_r;

   wire [2:0] div_nxt   = div_r + 3'h1;
   wire       slot_rise = (div_r == lpsr_pkg::CK_RISE_SLOT);
   wire       slot_fall = (div_r == lpsr_pkg::CK_FALL_SLOT);

   // APB decode
   wire setup    = psel & ~penable;
   wire wr       = psel & penable & pready_r & pwrite;
   wire hit_ctrl = (paddr == lpsr_pkg::OFS_CTRL);
   wire hit_cmd  = (paddr == lpsr_pkg::OFS_MRR_CMD);
   wire hit_data = (paddr == lpsr_pkg::OFS_MRR_DATA);
   wire hit_stat = (paddr == lpsr_pkg::OFS_STATUS);
   wire mapped   = hit_ctrl | hit_cmd | hit_data | hit_stat;
   wire in_sref  = (state_r == C_SRE) | (state_r == C_SREF) | (state_r == C_EXIT);
   wire busy     = (state_r != C_IDLE) | mrr_go_r;
   wire [2:0]  status  = {done_r, busy, in_sref};
   wire [31:0] rd_sel  = hit_ctrl ? {31'h0000_0000, sref_req_r} :
                         hit_data ? {24'h00_0000, mrr_data_r} :
                         hit_stat ? {29'h0000_0000, status} : 32'h0000_0000;

   // Read data capture on the first strobe rise of a burst
   wire dqs_s   = sync2_r[0];
   wire capture = (state_r == C_MRR_WAIT) & ~got_r & dqs_s & ~dqs_prev_r;
   wire issue_mrr = (state_r == C_IDLE) & slot_rise & ~sref_req_r & mrr_go_r;
   // Set beats clear when both meet in one cycle
   wire clr_done = wr & hit_stat & pwdata[lpsr_pkg::ST_DONE_BIT];

   always_comb
   begin
      state_nxt = state_r;
      cke_nxt   = cke_r;
      cs_n_nxt  = cs_n_r;
      ca_nxt    = ca_r;
      gap_nxt   = gap_r;
      cnt_nxt   = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
      case (state_r)
         C_IDLE:
         begin
            if (slot_rise)
            begin
               cs_n_nxt = 1'b1;
               // no activates are ever issued, banks stay idle
               // CKE was high through the previous cycle
               if (sref_req_r)
               begin
                  cke_nxt   = 1'b0;
                  cs_n_nxt  = 1'b0;
                  ca_nxt    = {7'h00, lpsr_pkg::CA_SREF};
                  state_nxt = C_SRE;
               end
               else if (mrr_go_r)
               begin
                  // high address bits with the rising edge
                  // no reads or writes precede it
                  cs_n_nxt  = 1'b0;
                  ca_nxt    = {mrr_addr_r[7:2], lpsr_pkg::CA_MRR};
                  state_nxt = C_MRR;
               end
            end
         end
         C_SRE:
         begin
            if (slot_rise)
            begin
               cs_n_nxt  = 1'b1;
               cnt_nxt   = 16'(lpsr_pkg::CKESR_CYC + lpsr_pkg::SYNC_MARGIN);
               state_nxt = C_SREF;
            end
         end
         C_SREF:
         begin
            // CKE held low until residency is met and exit is asked
            // the link clock never stops here
            if (slot_rise && cnt_r == 16'h0000 && !sref_req_r)
            begin
               cke_nxt   = 1'b1;
               cnt_nxt   = 16'(lpsr_pkg::XSR_CYC + lpsr_pkg::SYNC_MARGIN);
               state_nxt = C_EXIT;
            end
         end
         C_EXIT:
         begin
            // NOPs with CKE high until the interval ends
            if (slot_rise && cnt_r == 16'h0000)
            begin
               // all-bank refresh before any new entry
               cs_n_nxt  = 1'b0;
               ca_nxt    = {6'h00, lpsr_pkg::CA_ALL_BANK_REFRESH};
               state_nxt = C_REF;
            end
         end
         C_REF:
         begin
            if (slot_rise)
            begin
               cs_n_nxt  = 1'b1;
               state_nxt = C_IDLE;
            end
         end
         C_MRR:
         begin
            // low address bits with the falling edge
            if (slot_fall)
               ca_nxt = {8'h00, mrr_addr_r[1:0]};
            if (slot_rise)
            begin
               cs_n_nxt  = 1'b1;
               gap_nxt   = 2'(lpsr_pkg::MRR_GAP_CK);
               state_nxt = C_MRR_WAIT;
            end
         end
         C_MRR_WAIT:
         begin
            // NOPs until data is in and the burst has drained
            if (got_r && slot_rise)
            begin
               if (gap_r == 2'h0)
                  state_nxt = C_IDLE;
               else
                  gap_nxt = gap_r - 2'h1;
            end
         end
         default: state_nxt = C_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= C_IDLE;
         // Last slot of a low phase, so the first high phase is a full four cycles
         div_r   <= 3'h7;
         ck_r    <= 1'b0;
         cke_r   <= 1'b1;
         cs_n_r  <= 1'b1;
         ca_r    <= 10'h000;
         cnt_r   <= 16'h0000;
         gap_r   <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         div_r   <= div_nxt;
         ck_r    <= ~div_nxt[2];
         cke_r   <= cke_nxt;
         cs_n_r  <= cs_n_nxt;
         ca_r    <= ca_nxt;
         cnt_r   <= cnt_nxt;
         gap_r   <= gap_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r    <= 9'h000;
         sync2_r    <= 9'h000;
         dqs_prev_r <= 1'b0;
         got_r      <= 1'b0;
         mrr_data_r <= 8'h00;
         done_r     <= 1'b0;
      end
      else
      begin
         sync1_r    <= {link.dq[7:0], link.dqs[0]};
         sync2_r    <= sync1_r;
         dqs_prev_r <= dqs_s;
         got_r      <= capture | (got_r & ~issue_mrr);
         if (capture)
            mrr_data_r <= sync2_r[8:1];
         done_r     <= capture | (done_r & ~clr_done);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sref_req_r <= 1'b0;
         mrr_go_r   <= 1'b0;
         mrr_addr_r <= 8'h00;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         prdata_r   <= 32'h0000_0000;
      end
      else
      begin
         if (wr && hit_ctrl)
            sref_req_r <= pwdata[0];
         // A new read order while busy is dropped
         if (wr && hit_cmd && !busy)
         begin
            mrr_go_r   <= 1'b1;
            mrr_addr_r <= pwdata[7:0];
         end
         else if (issue_mrr)
            mrr_go_r <= 1'b0;
         pready_r  <= setup;
         pslverr_r <= setup & ~mapped;
         prdata_r  <= (setup & ~pwrite) ? rd_sel : 32'h0000_0000;
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign link.ck   = ck_r;
   assign link.cke  = cke_r;
   assign link.cs_n = cs_n_r;
   assign link.ca   = ca_r;

endmodule : lpsr_ctrl

//--- test/lpsr_monitor.sv
module lpsr_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Link
   input wire logic        ck,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic [9:0]  ca,
   input wire logic [15:0] dq_out,
   input wire logic        dq_oe,
   input wire logic [1:0]  dqs_out,
   input wire logic        dqs_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ck_divide: assert property (
      $rose(ck) |-> ck[*4] ##1 !ck[*4] ##1 ck) else $error("link clock period wrong");
   a_entry_code: assert property (
      $fell(cke) |-> !cs_n && ca[2:0] == lpsr_pkg::CA_SREF ##8 cs_n)
      else $error("entry code or following nop wrong");
   a_cke_residency: assert property (
      $fell(cke) |-> !cke[*8]) else $error("self refresh left too early");
   a_exit_nops: assert property (
      $rose(cke) |-> (cke && cs_n)[*8]) else $error("command inside exit interval");
   a_mrr_nop_period: assert property (
      $fell(cs_n) && cke && ca[3:0] == lpsr_pkg::CA_MRR |-> !cs_n[*8] ##1 cs_n[*8])
      else $error("mode read period not kept");
   a_burst_length: assert property (
      $rose(dq_oe) |-> dq_oe[*8] ##8 dq_oe ##1 !dq_oe) else $error("burst not four beats");
   a_upper_lane: assert property (
      dq_oe |-> dqs_oe && dq_out[15:8] == 8'h00) else $error("upper lane or strobe wrong");
   a_strobe_beats: assert property (
      $rose(dq_oe) |-> dqs_out == 2'b11 ##4 dqs_out == 2'b00 && dq_out[7:0] == 8'h00
      ##4 dqs_out == 2'b11) else $error("strobe or later beat wrong");
endmodule : lpsr_monitor

//--- test/lpsr_bench.sv
module lpsr_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary identification value
   localparam logic [7:0] VID = 8'hA7;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, mr_wr;
   logic [7:0]  paddr, mr_addr, mr_data, bank_en, seg_en;
   logic [31:0] pwdata, prdata, rd;
   logic        in_sr, gated, strobe, cmd_error;
   logic [2:0]  bank_count;
   int          miscompares, checked, cycles;

   lpsr_link_if link ();
   lpsr_ctrl lpsr_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .link(link.ctrl));
   lpsr_device #(.SR_REF_CYC(20), .VENDOR_ID(VID)) lpsr_device_i (.pclk, .presetn,
      .link(link.dev), .mr_wr, .mr_addr, .mr_data, .in_self_refresh(in_sr),
      .clk_gated(gated), .refresh_strobe(strobe), .refresh_bank_en(bank_en),
      .refresh_seg_en(seg_en), .bank_count, .cmd_error);
   lpsr_monitor lpsr_monitor_i (.pclk, .presetn, .ck(link.ck), .cke(link.cke),
      .cs_n(link.cs_n), .ca(link.ca), .dq_out(link.dq_out), .dq_oe(link.dq_oe),
      .dqs_out(link.dqs_out), .dqs_oe(link.dqs_oe));

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_st(input int b, input logic v);
      for (int k = 0; k < 200; k++)
      begin
         apb(1'b0, lpsr_pkg::OFS_STATUS, 32'h0000_0000);
         if (rd[b] === v)
            break;
      end
      chk("status", rd[b], v);
   endtask : wait_st

   task automatic test_regs;
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", er, 1'b1);
      apb(1'b0, lpsr_pkg::OFS_CTRL, 32'h0000_0000);
      chk("ctrl_reset", rd, 32'h0000_0000);
      $display("test regs done");
   endtask : test_regs

   task automatic test_mrr;
      apb(1'b1, lpsr_pkg::OFS_MRR_CMD, {24'h00_0000, lpsr_pkg::MR_VENDOR});
      wait_st(lpsr_pkg::ST_DONE_BIT, 1'b1);
      apb(1'b0, lpsr_pkg::OFS_MRR_DATA, 32'h0000_0000);
      chk("mrr_vendor", rd[7:0], VID);
      wait_st(lpsr_pkg::ST_BUSY_BIT, 1'b0);
      apb(1'b1, lpsr_pkg::OFS_STATUS, 32'h0000_0004);
      apb(1'b1, lpsr_pkg::OFS_MRR_CMD, {24'h00_0000, lpsr_pkg::MR_BANK_MASK});
      wait_st(lpsr_pkg::ST_DONE_BIT, 1'b1);
      apb(1'b0, lpsr_pkg::OFS_MRR_DATA, 32'h0000_0000);
      chk("mrr_mask", rd[7:0], 8'h00);
      $display("test mode read done");
   endtask : test_mrr

   task automatic mr(input logic [7:0] a, input logic [7:0] d);
      mr_wr <= 1'b1;
      mr_addr <= a;
      mr_data <= d;
      @(posedge pclk);
      mr_wr <= 1'b0;
      @(posedge pclk);
   endtask : mr

   task automatic test_sref;
      int n;
      n = 0;
      mr(lpsr_pkg::MR_BANK_MASK, 8'h82);
      mr(lpsr_pkg::MR_SEG_MASK, 8'h84);
      apb(1'b1, lpsr_pkg::OFS_CTRL, 32'h0000_0001);
      wait_st(lpsr_pkg::ST_SREF_BIT, 1'b1);
      chk("bank_en", bank_en, 8'h7D);
      chk("seg_en", seg_en, 8'h7B);
      repeat (100) @(posedge pclk) n += int'(strobe === 1'b1);
      chk("strobes", n, 5);
      chk("gated", gated, 1'b1);
      chk("in_sr", in_sr, 1'b1);
      apb(1'b1, lpsr_pkg::OFS_CTRL, 32'h0000_0000);
      wait_st(lpsr_pkg::ST_SREF_BIT, 1'b0);
      chk("in_sr_exit", in_sr, 1'b0);
      chk("bank_count", bank_count, 3'h0);
      chk("cmd_error", cmd_error, 1'b0);
      $display("test self refresh done");
   endtask : test_sref

   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         print_verdict;
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, mr_wr, cycles} = '0;
      {paddr, pwdata, mr_addr, mr_data} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      test_regs;
      test_mrr;
      test_sref;
      print_verdict;
   end
endmodule : lpsr_bench
